// File: logic/flash_read_pkg.sv
// Purpose: Constants for the serial flash read command sequencer
// Assumes: Serial clock domain faces the link, sys_clk faces the array side
// Notes: Opcodes, dummy and mode cycle counts and the address reset value live here; address lengths are in the sequencer
package flash_read_pkg;
    localparam logic [7:0] OP_READ3 = 8'h03;
    localparam logic [7:0] OP_READ4 = 8'h13;
    localparam logic [7:0] OP_FAST3 = 8'h0B;
    localparam logic [7:0] OP_FAST4 = 8'h0C;
    localparam logic [7:0] OP_DOR3 = 8'h3B;
    localparam logic [7:0] OP_DOR4 = 8'h3C;
    localparam logic [7:0] OP_QOR3 = 8'h6B;
    localparam logic [7:0] OP_QOR4 = 8'h6C;
    localparam logic [7:0] OP_DIO3 = 8'hBB;
    localparam logic [7:0] OP_DIO4 = 8'hBC;
    localparam logic [3:0] MODE_KEEP = 4'hA;
    localparam int ADDR_W = 26;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 26'h000_0000;
    localparam logic [ADDR_W-1:0] ADDR_TOP = 26'h3FF_FFFF;
    localparam int QUAD_BIT = 1;
    localparam logic [5:0] FAST_DUMMY = 6'h08;
    localparam logic [5:0] MODE_CYCLES = 6'h04;
    localparam logic [5:0] SHORT_PULSE = 6'h08;
    localparam logic [1:0] LC_NONE = 2'h3;
    localparam logic [1:0] WIDTH_1 = 2'h0;
    localparam logic [1:0] WIDTH_2 = 2'h1;
    localparam logic [1:0] WIDTH_4 = 2'h2;
    localparam logic [1:0] SYNC_RESET = 2'h0;
endpackage

// File: logic/array_link_if.sv
// Purpose: Byte fetch carrier between link logic and array port logic
// Assumes: Request is a toggle from the link clock domain
// Notes: Address holds stable while a toggle is outstanding
interface array_link_if;
    import flash_read_pkg::*;
    logic req_toggle;
    logic ack_toggle;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
    modport link (output req_toggle, output addr, input ack_toggle, input data);
    modport fetch (input req_toggle, input addr, output ack_toggle, output data);
endinterface

// File: logic/array_fetch.sv
// Purpose: Fetches one array byte per request toggle on sys_clk
// Assumes: Array read data returns one cycle after address
// Notes: Data register loads on the same edge that ack toggles back
module array_fetch
    import flash_read_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    array_link_if.fetch lnk,
    output logic [ADDR_W-1:0] array_addr,
    input wire logic [7:0] array_rdata
);
    logic [2:0] req_sync;
    logic pending;
    logic fetch_wait;
    logic ack;
    logic [7:0] data;
    // Three stage sync, second and third agree before counting
    wire req_event = (req_sync[2] == req_sync[1]) && (req_sync[1] != ack) && !pending && !fetch_wait;
    assign lnk.ack_toggle = ack;
    assign lnk.data = data;
    // Address is stable across the handshake, so sampled directly
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            req_sync <= 3'h0;
            pending <= 1'b0;
            fetch_wait <= 1'b0;
            ack <= 1'b0;
            data <= 8'h00;
            array_addr <= ADDR_ZERO;
        end else begin
            req_sync <= {req_sync[1:0], lnk.req_toggle};
            pending <= req_event;
            // Array answers a cycle after the address, so data is taken one cycle later
            fetch_wait <= pending;
            if (req_event) array_addr <= lnk.addr;
            if (fetch_wait) begin
                data <= array_rdata;
                ack <= ~ack;
            end
        end
    end
endmodule

// File: logic/flash_read_seq.sv
// Purpose: Serial read command decoder and data streamer
// Assumes: Mode 0 serial clock; host obeys clock limits and turnaround
// Notes: Link logic runs on serial clock, array port on sys_clk
module flash_read_seq
    import flash_read_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ser_clk,
    input wire logic cs_n,
    input wire logic [3:0] bidir_data_lanes_in,
    output logic [3:0] bidir_data_lanes_out,
    output logic [3:0] bidir_data_lanes_oe,
    input wire logic four_byte_addr_bit,
    input wire logic [1:0] latency_code,
    input wire logic [7:0] config_register_one,
    input wire logic enhanced_latency_table,
    output logic continuous_mode,
    output logic [ADDR_W-1:0] array_addr,
    input wire logic [7:0] array_rdata
);
    // Gray coded phases along the command path
    typedef enum logic [2:0] {
        ST_OPCODE = 3'b000,
        ST_ADDR = 3'b001,
        ST_MODE = 3'b011,
        ST_DUMMY = 3'b010,
        ST_DATA = 3'b110,
        ST_IGNORE = 3'b111
    } phase_e;

    array_link_if lnk();

    // Bits per serial cycle for a lane width
    function automatic logic [5:0] lane_bits(input logic [1:0] w);
        case (w)
            WIDTH_2: lane_bits = 6'd2;
            WIDTH_4: lane_bits = 6'd4;
            default: lane_bits = 6'd1;
        endcase
    endfunction

    phase_e phase;
    logic [7:0] opcode_sr;
    logic [5:0] bit_cnt;
    logic [31:0] addr_sr;
    logic [5:0] addr_bits;
    logic [1:0] in_width;
    logic [1:0] out_width;
    logic [5:0] dummy_left;
    logic [7:0] mode_sr;
    logic mode_keep;
    logic in_cont;
    logic [ADDR_W-1:0] rd_addr;
    logic req_toggle;
    logic [7:0] shift_byte;
    logic [5:0] data_bits;
    logic [5:0] pulse_cnt;
    logic saw_opcode;

    // Opcode decode, all read opcodes and address length
    wire [7:0] op_now = {opcode_sr[6:0], bidir_data_lanes_in[0]};
    wire op_is_read = (op_now == OP_READ3) || (op_now == OP_READ4);
    wire op_is_fast = (op_now == OP_FAST3) || (op_now == OP_FAST4);
    wire op_is_dor = (op_now == OP_DOR3) || (op_now == OP_DOR4);
    wire op_is_qor = ((op_now == OP_QOR3) || (op_now == OP_QOR4))
        && config_register_one[QUAD_BIT];
    wire op_is_dio = (op_now == OP_DIO3) || (op_now == OP_DIO4);
    wire op_valid = op_is_read || op_is_fast || op_is_dor || op_is_qor || op_is_dio;
    // 4-byte opcodes fixed, legacy ones follow the extended bit
    wire op_four = (op_now == OP_READ4) || (op_now == OP_FAST4) || (op_now == OP_DOR4)
        || (op_now == OP_QOR4) || (op_now == OP_DIO4) || four_byte_addr_bit;
    wire [5:0] addr_len = op_four ? 6'd32 : 6'd24;
    wire [5:0] cont_addr_len = four_byte_addr_bit ? 6'd32 : 6'd24;
    // Latency code picks zero or eight cycles
    wire [5:0] lat_cycles = (latency_code == LC_NONE) ? 6'd0 : FAST_DUMMY;
    // Mode cycles count toward latency in the enhanced table
    wire [5:0] dio_dummy = (lat_cycles > MODE_CYCLES) ? lat_cycles - MODE_CYCLES : 6'd0;

    // Address shift: one or two bits per rising edge, MSB first
    wire [31:0] addr_next = (in_width == WIDTH_2) ? {addr_sr[29:0], bidir_data_lanes_in[1:0]}
        : {addr_sr[30:0], bidir_data_lanes_in[0]};
    wire [5:0] bits_next = bit_cnt + lane_bits(in_width);
    wire addr_done = (phase == ST_ADDR) && (bits_next >= addr_bits);
    wire [7:0] mode_next = {mode_sr[5:0], bidir_data_lanes_in[1:0]};
    wire [ADDR_W-1:0] inc_addr = (rd_addr == ADDR_TOP) ? ADDR_ZERO : rd_addr + 1'b1;
    wire [5:0] out_bits = lane_bits(out_width);
    // One fetch per byte, issued on the rising edge after the byte is loaded,
    // so the array has most of a byte time to answer
    wire need_next = (phase == ST_DATA) && (data_bits == out_bits);

    // Link phase machine; cs_n high acts as reset for each command
    always_ff @(posedge ser_clk or posedge cs_n) begin
        if (cs_n) begin
            phase <= ST_OPCODE;
            opcode_sr <= 8'h00;
            bit_cnt <= 6'd0;
            addr_sr <= 32'h0000_0000;
            addr_bits <= 6'd24;
            in_width <= WIDTH_1;
            out_width <= WIDTH_1;
            dummy_left <= 6'd0;
            mode_sr <= 8'h00;
            pulse_cnt <= 6'd0;
            saw_opcode <= 1'b0;
        end else begin
            if (pulse_cnt != 6'h3F) pulse_cnt <= pulse_cnt + 6'd1;
            case (phase)
                ST_OPCODE: begin
                    opcode_sr <= op_now;
                    bit_cnt <= bit_cnt + 6'd1;
                    if (bit_cnt == 6'd7) begin
                        bit_cnt <= 6'd0;
                        saw_opcode <= op_valid;
                        addr_bits <= addr_len;
                        in_width <= op_is_dio ? WIDTH_2 : WIDTH_1;
                        out_width <= op_is_qor ? WIDTH_4 : ((op_is_dor || op_is_dio) ? WIDTH_2 : WIDTH_1);
                        dummy_left <= op_is_read ? 6'd0 : (op_is_dio
                            ? (enhanced_latency_table ? dio_dummy : lat_cycles) : lat_cycles);
                        phase <= op_valid ? ST_ADDR : ST_IGNORE;
                    end
                end
                ST_ADDR: begin
                    addr_sr <= addr_next;
                    bit_cnt <= bits_next;
                    if (addr_done) begin
                        bit_cnt <= 6'd0;
                        if (in_width == WIDTH_2 && enhanced_latency_table) phase <= ST_MODE;
                        else if (dummy_left != 6'd0) phase <= ST_DUMMY;
                        else phase <= ST_DATA;
                    end
                end
                ST_MODE: begin
                    mode_sr <= mode_next;
                    bit_cnt <= bit_cnt + 6'd1;
                    if (bit_cnt == MODE_CYCLES - 6'd1) begin
                        bit_cnt <= 6'd0;
                        phase <= (dummy_left != 6'd0) ? ST_DUMMY : ST_DATA;
                    end
                end
                ST_DUMMY: begin
                    // Lane values are not looked at here
                    dummy_left <= dummy_left - 6'd1;
                    if (dummy_left == 6'd1) phase <= ST_DATA;
                end
                ST_DATA: phase <= ST_DATA;
                ST_IGNORE: phase <= ST_IGNORE;
                default: phase <= ST_OPCODE;
            endcase
            // Continuous mode entry skips the opcode
            if (phase == ST_OPCODE && bit_cnt == 6'd0 && in_cont) begin
                phase <= ST_ADDR;
                addr_sr <= {30'h0, bidir_data_lanes_in[1:0]};
                bit_cnt <= 6'd2;
                addr_bits <= cont_addr_len;
                in_width <= WIDTH_2;
                out_width <= WIDTH_2;
                dummy_left <= dio_dummy;
                // Opcode flag stays clear: a short pulse here must still end the mode
            end
        end
    end

    // Continuous mode decided at each select rise from the mode byte
    always_ff @(posedge cs_n or posedge rst) begin
        if (rst) in_cont <= 1'b0;
        else if (!saw_opcode && pulse_cnt <= SHORT_PULSE) in_cont <= 1'b0;
        else in_cont <= mode_keep;
    end
    // Mode keep flag latched when mode phase ends, cleared when an opcode completes
    always_ff @(posedge ser_clk or posedge rst) begin
        if (rst) mode_keep <= 1'b0;
        else if (!cs_n && phase == ST_MODE && bit_cnt == MODE_CYCLES - 6'd1)
            mode_keep <= (mode_next[7:4] == MODE_KEEP);
        else if (!cs_n && phase == ST_OPCODE && bit_cnt == 6'd7)
            mode_keep <= 1'b0;
    end
    assign continuous_mode = in_cont;

    // Fetch requests: one at address end, then one early in each byte
    always_ff @(posedge ser_clk or posedge rst) begin
        if (rst) begin
            req_toggle <= 1'b0;
            rd_addr <= ADDR_ZERO;
        end else if (!cs_n && addr_done) begin
            rd_addr <= addr_next[ADDR_W-1:0];
            req_toggle <= ~req_toggle;
        end else if (!cs_n && need_next) begin
            rd_addr <= inc_addr;
            req_toggle <= ~req_toggle;
        end
    end
    assign lnk.req_toggle = req_toggle;
    assign lnk.addr = rd_addr;
    // Fetched byte is read at byte start; it has stood since the answer.
    // Limitation: with no dummy cycles the host must stretch the last clock high

    // Output shifter on falling edge, MSB first
    always_ff @(negedge ser_clk or posedge cs_n) begin
        if (cs_n) begin
            shift_byte <= 8'h00;
            data_bits <= 6'd0;
            bidir_data_lanes_oe <= 4'h0;
            bidir_data_lanes_out <= 4'h0;
        end else if (phase == ST_DATA) begin
            logic [7:0] cur;
            cur = (data_bits == 6'd0) ? lnk.data : shift_byte;
            case (out_width)
                WIDTH_4: begin
                    bidir_data_lanes_out <= cur[7:4];
                    bidir_data_lanes_oe <= 4'hF;
                end
                WIDTH_2: begin
                    bidir_data_lanes_out <= {2'b00, cur[7:6]};
                    bidir_data_lanes_oe <= 4'h3;
                end
                default: begin
                    bidir_data_lanes_out <= {2'b00, cur[7], 1'b0};
                    bidir_data_lanes_oe <= 4'h2;
                end
            endcase
            shift_byte <= cur << out_bits;
            data_bits <= (data_bits + out_bits >= 6'd8) ? 6'd0 : data_bits + out_bits;
        end else begin
            bidir_data_lanes_oe <= 4'h0;
        end
    end

    array_fetch fetch_u (
        .sys_clk(sys_clk),
        .rst(rst),
        .lnk(lnk),
        .array_addr(array_addr),
        .array_rdata(array_rdata)
    );

    // Data lanes only driven in data phase
    a_lanes_quiet: assert property (@(posedge ser_clk) disable iff (rst || cs_n)
        (phase != ST_DATA && $past(phase) != ST_DATA) |-> bidir_data_lanes_oe == 4'h0)
        else $error("Lanes driven outside data phase");
    a_quad_gate: assert property (@(posedge ser_clk) disable iff (rst || cs_n)
        bidir_data_lanes_oe == 4'hF |-> config_register_one[QUAD_BIT])
        else $error("Quad output without quad enable");
    a_wrap_zero: assert property (@(posedge ser_clk) disable iff (rst || cs_n)
        (need_next && rd_addr == ADDR_TOP) |=> rd_addr == ADDR_ZERO)
        else $error("Address did not wrap to zero");
    a_dummy_len: assert property (@(posedge ser_clk) disable iff (rst || cs_n)
        (phase == ST_DUMMY && dummy_left == 6'd1) |=> phase == ST_DATA)
        else $error("Dummy phase length wrong");
    // Byte must be back from the array before the shifter loads it
    a_fetch_ready: assert property (@(negedge ser_clk) disable iff (rst || cs_n)
        (phase == ST_DATA && data_bits == 6'd0) |-> lnk.ack_toggle == lnk.req_toggle)
        else $error("Array byte not ready at byte start");
    a_ext_addr_len: assert property (@(posedge ser_clk) disable iff (rst || cs_n)
        (phase == ST_OPCODE && bit_cnt == 6'd7 && op_valid && four_byte_addr_bit) |=> addr_bits == 6'd32)
        else $error("Extended bit did not select four address bytes");
    a_cont_exit: assert property (@(posedge cs_n) disable iff (rst)
        !mode_keep |=> !in_cont)
        else $error("Continuous mode kept without keep pattern");
endmodule

// File: sim/spi_host_model.sv
// Purpose: Host memory controller model driving select, serial clock and lanes
// Assumes: Mode 0, clock low and still between frames, 48 ns period
// Notes: Released lanes toggle so a stale value never looks valid
module spi_host_model (
    output logic ser_clk,
    output logic cs_n,
    output logic [3:0] host_lanes,
    output logic host_oe,
    input wire logic [3:0] lane_wire
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] got[$];
    initial begin
        ser_clk = 1'b0;
        cs_n = 1'b1;
        host_lanes = 4'h0;
        host_oe = 1'b0;
    end
    // Undriven lanes change every cycle, dummy values ignored by device
    always @(negedge ser_clk) if (!host_oe) host_lanes <= ~host_lanes;
    // One clock, sampled at the rising edge
    // A hold stretches the high phase and releases the lanes during it
    task tick(output logic [3:0] s, input int hold = 0);
        #24 ser_clk = 1'b1;
        s = lane_wire;
        if (hold > 0) host_oe = 1'b0;
        #(24 + hold) ser_clk = 1'b0;
    endtask
    // MSB first, lane 1 carries the upper bit of a pair
    task shift(input logic [31:0] v, input int nbits, input int w, input int hold);
        logic [3:0] s;
        for (int i = nbits - w; i >= 0; i -= w) begin
            host_oe = 1'b1;
            host_lanes = (w == 1) ? {3'b000, v[i]} : {2'b00, v[i+1], v[i]};
            tick(s, (i == 0) ? hold : 0);
        end
    endtask
    task frame(input logic [7:0] op, input bit send_op, input logic [31:0] addr, input int nab, input int aw,
               input bit has_mode, input logic [7:0] mode, input int dummy, input int dw, input int nbytes);
        logic [3:0] s;
        logic [7:0] b;
        int stretch;
        // No dummy cycles: last clock stays high so the first byte can be fetched
        stretch = (dummy == 0) ? 72 : 0;
        got.delete();
        cs_n = 1'b0;
        #24;
        if (send_op) shift({24'h00_0000, op}, 8, 1, 0);
        shift(addr, nab * 8, aw, has_mode ? 0 : stretch);
        if (has_mode) shift({24'h00_0000, mode}, 8, 2, stretch);
        host_oe = 1'b0; // Off before first data edge
        repeat (dummy) tick(s);
        for (int k = 0; k < nbytes; k++) begin
            b = 8'h00;
            for (int j = 0; j < 8; j += dw) begin
                tick(s);
                b = (b << dw) | 8'((dw == 1) ? s[1] : (dw == 2) ? s[1:0] : s);
            end
            got.push_back(b);
        end
        #24 cs_n = 1'b1; // Raised after the last data byte
        #96;
    endtask
    // Short select pulse carrying no valid opcode
    task pulse(input int n, input logic [3:0] v);
        logic [3:0] s;
        cs_n = 1'b0;
        host_oe = 1'b1;
        host_lanes = v;
        #24;
        repeat (n) tick(s);
        host_oe = 1'b0;
        #24 cs_n = 1'b1;
        #96;
    endtask
endmodule

// File: sim/serial_flash_read_commands_test.sv
// Purpose: Self-checking bench for the serial read sequencer
// Assumes: Array model answers one sys_clk after the address
// Notes: Random addresses and settings from a fixed seed
module serial_flash_read_commands_test
    import flash_read_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic ser_clk, cs_n, host_oe, four_byte_addr_bit, enhanced_latency_table, continuous_mode, oe_seen;
    logic [3:0] host_lanes, lanes_wire, dout, oe, s;
    logic [1:0] latency_code, lc;
    logic [7:0] config_register_one, array_rdata, op;
    logic [ADDR_W-1:0] array_addr, a;
    integer seed = 65;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;
    int nab, aw, dw, dm;
    logic [7:0] ops[10] = '{OP_READ3, OP_READ4, OP_FAST3, OP_FAST4, OP_DOR3, OP_DOR4, OP_QOR3, OP_QOR4,
                            OP_DIO3, OP_DIO4};
    always #5 sys_clk = ~sys_clk;
    // Wire level from the device enables; host value where they are off
    assign lanes_wire = (oe & dout) | (~oe & host_lanes);
    spi_host_model host (.ser_clk(ser_clk), .cs_n(cs_n), .host_lanes(host_lanes), .host_oe(host_oe),
                         .lane_wire(lanes_wire));
    flash_read_seq DUT (.sys_clk(sys_clk), .rst(rst), .ser_clk(ser_clk), .cs_n(cs_n),
        .bidir_data_lanes_in(lanes_wire), .bidir_data_lanes_out(dout), .bidir_data_lanes_oe(oe),
        .four_byte_addr_bit(four_byte_addr_bit), .latency_code(latency_code),
        .config_register_one(config_register_one), .enhanced_latency_table(enhanced_latency_table),
        .continuous_mode(continuous_mode), .array_addr(array_addr), .array_rdata(array_rdata));
    // Array contents as a function of address
    function automatic logic [7:0] mem_byte(input logic [ADDR_W-1:0] x);
        return x[7:0] ^ x[15:8] ^ x[25:18];
    endfunction
    always @(posedge sys_clk) array_rdata <= mem_byte(array_addr);
    always @(posedge ser_clk) if (!cs_n && oe !== 4'h0) oe_seen <= 1'b1;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 30000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    task check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Settings change only while the link is idle
    task automatic cfg(input logic ext, input logic [1:0] l, input logic enh, input logic quad);
        @(posedge sys_clk);
        four_byte_addr_bit <= ext;
        latency_code <= l;
        enhanced_latency_table <= enh;
        config_register_one <= (8'($random(seed)) & 8'hFD) | {6'h00, quad, 1'b0};
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] o, input bit snd, input logic [ADDR_W-1:0] x, input int nb, input int w,
                      input bit hm, input logic [7:0] m, input int d, input int ww, input int n);
        host.frame(o, snd, {6'h00, x}, nb, w, hm, m, d, ww, n);
        for (int k = 0; k < n; k++) check(host.got[k], mem_byte(x + ADDR_W'(k)));
        check(oe, 4'h0);
    endtask
    initial begin
        four_byte_addr_bit = 1'b0;
        latency_code = 2'h0;
        config_register_one = 8'h00;
        enhanced_latency_table = 1'b0;
        oe_seen = 1'b0;
        repeat (2) host.tick(s);
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        // Every opcode, both address modes, both dummy settings
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 10; i++) begin
                op = ops[i];
                lc = (p == 0) ? LC_NONE : 2'(i % 3);
                cfg(1'($random(seed)), lc, 1'b0, 1'b1);
                nab = (four_byte_addr_bit || op inside {OP_READ4, OP_FAST4, OP_DOR4, OP_QOR4, OP_DIO4}) ? 4 : 3;
                a = 26'($random(seed));
                if (nab == 3) a[25:24] = 2'b00;
                dm = (op inside {OP_READ3, OP_READ4} || lc == LC_NONE) ? 0 : 8;
                dw = (op inside {OP_DOR3, OP_DOR4, OP_DIO3, OP_DIO4}) ? 2 : (op inside {OP_QOR3, OP_QOR4}) ? 4 : 1;
                aw = (op inside {OP_DIO3, OP_DIO4}) ? 2 : 1;
                rd(op, 1, a, nab, aw, 0, 8'h00, dm, dw, 3);
                check(continuous_mode, 1'b0);
            end
        end
        // Wrap from the top of the array
        cfg(1'b1, LC_NONE, 1'b0, 1'b1);
        rd(OP_READ4, 1, 26'h3FF_FFFE, 4, 1, 0, 8'h00, 0, 1, 4);
        // Quad read refused while quad enable is clear
        cfg(1'b0, 2'h0, 1'b0, 1'b0);
        oe_seen = 1'b0;
        host.frame(OP_QOR3, 1, 32'h0000_1234, 3, 1, 0, 8'h00, 8, 4, 2);
        check(oe_seen, 1'b0);
        // Enhanced table: mode cycles, continuous entry and exits
        cfg(1'b0, 2'h0, 1'b1, 1'b1);
        rd(OP_DIO3, 1, 26'h012_3456, 3, 2, 1, 8'hA5, 4, 2, 3);
        check(continuous_mode, 1'b1);
        rd(OP_DIO3, 0, 26'h0AB_CDEF, 3, 2, 1, 8'h00, 4, 2, 3);
        check(continuous_mode, 1'b0);
        rd(OP_DIO3, 1, 26'h000_0100, 3, 2, 1, 8'hAF, 4, 2, 2);
        check(continuous_mode, 1'b1);
        host.pulse(4, 4'hF);
        check(continuous_mode, 1'b0);
        rd(OP_FAST3, 1, 26'h000_0200, 3, 1, 0, 8'h00, 8, 1, 2);
        tally_and_finish();
    end
endmodule
